// *** prio_pkg.sv ***
// package for the interrupt priority register block: offsets, field layout, reset values
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package prio_pkg;

  // register map (byte addresses)
  localparam logic [3:0]  prio_reg_off      = 4'h0;  // the priority register
  localparam logic [3:0]  status_reg_off    = 4'h4;  // effective levels, read only
  localparam int          addr_w            = 4;

  // field positions inside the priority register
  localparam int          can_event_lsb     = 12;
  localparam int          can_rx_ready_lsb  = 8;
  localparam int          spi_event_lsb     = 4;
  localparam int          spi_error_lsb     = 0;
  localparam int          field_w           = 3;
  localparam int          num_src           = 4;

  // writable bits; bits 15, 11, 7 and 3 stay zero
  localparam logic [15:0] prio_impl_mask    = 16'h7777;
  // every field comes out of reset at level 4
  localparam logic [15:0] prio_reset_val    = 16'h4444;

  // level codes
  localparam logic [2:0]  level_off         = 3'h0;
  localparam logic [2:0]  level_max         = 3'h7;

  // axi response codes
  localparam logic [1:0]  resp_okay         = 2'h0;
  localparam logic [1:0]  resp_slverr       = 2'h2;

endpackage

// *** prio_field_decode.sv ***
// decodes one 3-bit priority field into an enable and an effective level
// assumes the field value comes straight from the register flops
`timescale 1ns/100ps
module prio_field_decode
  import prio_pkg::*;
(
  // field in
  input  wire logic [2:0] field,
  input  wire logic       present,
  // decoded out
  output logic            enabled,
  output logic [2:0]      level
);

  // absent source or code 000 means the source is never taken
  assign enabled = present && (field != level_off);
  // codes 001..111 are the levels themselves, 111 being the top
  assign level   = enabled ? field : level_off;

endmodule // prio_field_decode

// *** prio_req_gate.sv ***
// masks each source request by its enable and reports the highest pending level
// assumes requests are synchronous levels in the aclk domain
`timescale 1ns/100ps
module prio_req_gate
  import prio_pkg::*;
#(
  parameter int N = 4
)
(
  // per-source inputs
  input  wire logic [N-1:0]   req,
  input  wire logic [N-1:0]   en,
  input  wire logic [3*N-1:0] levels,
  // summary
  output logic [2:0]          top_level
);

  initial begin
    if (N < 1) $error("prio_req_gate needs at least one source");
  end

  // a disabled source contributes level zero even while pending
  always_comb begin
    top_level = level_off;
    for (int i = 0; i < N; i++) begin
      if (req[i] && en[i] && (levels[3*i +: 3] > top_level)) begin
        top_level = levels[3*i +: 3];
      end
    end
  end

endmodule // prio_req_gate

// *** can_spi_irq_priority_reg.sv ***
// interrupt priority register for the can and spi channel 2 sources, on axi4-lite
// assumes one clock aclk with synchronous active-low reset; requests are aclk levels
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module can_spi_irq_priority_reg
  import prio_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pending requests: [3] can event, [2] can rx, [1] spi event, [0] spi error
  input  wire logic [3:0]  src_req,
  // decoded priorities toward the arbiter
  output logic [3:0]       src_enabled,
  output logic [11:0]      src_level,
  output logic [2:0]       top_level
);

  // register state
  logic [15:0] prio_r;
  logic [15:0] prio_nxt;
  logic        aw_held_r;
  logic        w_held_r;
  logic [3:0]  awaddr_r;
  logic [15:0] wdata_r;
  logic [1:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [11:0] level_r;
  logic [3:0]  enabled_r;
  logic [2:0]  top_r;

  // write channel: take address and data in either order, answer once both are in
  wire         aw_take    = s_axi_awvalid && s_axi_awready;
  wire         w_take     = s_axi_wvalid && s_axi_wready;
  wire         aw_have    = aw_held_r || aw_take;
  wire         w_have     = w_held_r || w_take;
  wire         wr_fire    = aw_have && w_have && !bvalid_r;
  wire [3:0]   wr_addr    = aw_held_r ? awaddr_r : s_axi_awaddr[3:0];
  wire [15:0]  wr_data    = w_held_r ? wdata_r : s_axi_wdata[15:0];
  wire [1:0]   wr_strb    = w_held_r ? wstrb_r : s_axi_wstrb[1:0];
  wire         wr_hit     = (wr_addr == prio_reg_off) && (s_axi_awaddr[31:4] == 28'h0
                            || aw_held_r);
  wire         wr_ro      = (wr_addr == status_reg_off);
  wire [15:0]  byte_mask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // new register value: only implemented bits of enabled lanes change
  assign prio_nxt = wr_fire && wr_hit
                  ? ((prio_r & ~(byte_mask & prio_impl_mask))
                     | (wr_data & byte_mask & prio_impl_mask))
                  : prio_r;

  // the priority register itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_r <= prio_reset_val;
    end else begin
      prio_r <= prio_nxt;
    end
  end

  // hold address or data that arrived before its partner
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 16'h0;
      wstrb_r   <= 2'h0;
    end else begin
      aw_held_r <= wr_fire ? 1'b0 : aw_have;
      w_held_r  <= wr_fire ? 1'b0 : w_have;
      if (aw_take) awaddr_r <= s_axi_awaddr[3:0];
      if (w_take) begin
        wdata_r <= s_axi_wdata[15:0];
        wstrb_r <= s_axi_wstrb[1:0];
      end
    end
  end

  // write response: writes to the read-only status word or holes answer slverr, except a hole whose address is held, which is matched on bits 3:0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= resp_okay;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_hit && !wr_ro) ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel: one read at a time, data one cycle after the address is taken
  wire         ar_take    = s_axi_arvalid && s_axi_arready;
  wire         rd_prio    = s_axi_araddr == {28'h0, prio_reg_off};
  wire         rd_stat    = s_axi_araddr == {28'h0, status_reg_off};
  wire [31:0]  rd_word    = rd_prio ? {16'h0, prio_r & prio_impl_mask}
                          : rd_stat ? {13'h0, top_r, 4'h0, level_r}
                          : 32'h0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // read data register; unmapped addresses read zero with slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= resp_okay;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= (rd_prio || rd_stat) ? resp_okay : resp_slverr;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // field decode: can sources depend on the can module being fitted
  wire [2:0]   fld [num_src];
  wire [3:0]   present    = {HAS_CAN, HAS_CAN, 1'b1, 1'b1};
  wire [3:0]   en_w;
  wire [11:0]  lvl_w;
  wire [2:0]   top_w;

  assign fld[3] = prio_r[can_event_lsb    +: field_w];
  assign fld[2] = prio_r[can_rx_ready_lsb +: field_w];
  assign fld[1] = prio_r[spi_event_lsb    +: field_w];
  assign fld[0] = prio_r[spi_error_lsb    +: field_w];

  for (genvar i = 0; i < num_src; i++) begin : g_dec
    prio_field_decode u_dec (
      .field   (fld[i]),
      .present (present[i]),
      .enabled (en_w[i]),
      .level   (lvl_w[3*i +: 3])
    );
  end

  // pending sources masked by enable; disabled ones never win
  prio_req_gate #(.N(num_src)) u_gate (
    .req       (src_req),
    .en        (en_w),
    .levels    (lvl_w),
    .top_level (top_w)
  );

  // register the decoded outputs so data outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enabled_r <= 4'h0;
      level_r   <= 12'h0;
      top_r     <= level_off;
    end else begin
      enabled_r <= en_w;
      level_r   <= lvl_w;
      top_r     <= top_w;
    end
  end

  assign src_enabled = enabled_r;
  assign src_level   = level_r;
  assign top_level   = top_r;

endmodule // can_spi_irq_priority_reg

// *** prio_reg_checker.sv ***
// checker for the priority register block: axi handshakes and decoded outputs
// assumes it is bound onto the top module and sees only its ports, one aclk domain
`timescale 1ns/100ps
module prio_reg_checker #(
  parameter bit HAS_CAN = 1'b1
) (
  // clock, reset and handshakes
  input wire logic        aclk, aresetn,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // decoded side
  input wire logic [3:0]  src_req, src_enabled,
  input wire logic [11:0] src_level,
  input wire logic [2:0]  top_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a level of zero must mean disabled, any other level enabled
  wire logic [3:0] lvl_nz = {|src_level[11:9], |src_level[8:6], |src_level[5:3], |src_level[2:0]};
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_enable_matches: assert property (lvl_nz == src_enabled)
    else $error("enable and level disagree");
  a_no_can_off: assert property (!HAS_CAN |-> src_enabled[3:2] == 2'h0)
    else $error("can source enabled without can");
  a_reset_levels: assert property (disable iff (1'b0) !aresetn ##1 aresetn |=>
    src_level == (HAS_CAN ? 12'h924 : 12'h024)) else $error("reset levels wrong");
  a_idle_top_zero: assert property (src_req == 4'h0 |=> top_level == 3'h0)
    else $error("top level without request");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response waits");
  a_write_answer: assert property (wr_both |=> s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
endmodule // prio_reg_checker

bind can_spi_irq_priority_reg prio_reg_checker #(.HAS_CAN(HAS_CAN)) u_chk (.*);

// *** can_spi_irq_priority_reg_tb.sv ***
// self-checking bench: axi4-lite traffic and requests against a bench model
// assumes the package and the bound checker are compiled before this file
`timescale 1ns/100ps
module can_spi_irq_priority_reg_tb;
  import prio_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, src_req, src_enabled;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] src_level;
  logic [2:0]  top_level;
  logic [3:0]  en_nc;   // enables of a second copy built without the can module
  logic [15:0] prio_m;  // bench copy of the register
  int          num_errors = 0;
  int          checks = 0;

  can_spi_irq_priority_reg DUT (.*);

  // same traffic into a variant without can, so its can sources must stay off
  can_spi_irq_priority_reg #(.HAS_CAN(1'b0)) DUT_nc (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (),
    .s_axi_bresp   (),
    .s_axi_bvalid  (),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (),
    .s_axi_rdata   (),
    .s_axi_rresp   (),
    .s_axi_rvalid  (),
    .s_axi_rready  (s_axi_rready),
    .src_req       (src_req),
    .src_enabled   (en_nc),
    .src_level     (),
    .top_level     ()
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // model of the decoded outputs, one field per source
  function automatic logic [2:0] fld(int i);
    return prio_m[4*i +: 3];
  endfunction
  function automatic logic [31:0] exp_stat();
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < 4; i++) begin
      e[3*i +: 3] = fld(i);
      if (src_req[i] && fld(i) > e[18:16]) e[18:16] = fld(i);
    end
    return e;
  endfunction
  // a source is enabled whenever its field is not code 000
  function automatic logic [3:0] exp_en();
    logic [3:0] e;
    for (int i = 0; i < 4; i++) e[i] = (fld(i) != 3'h0);
    return e;
  endfunction

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] dat, logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    s_axi_bready <= 1'b0;
    cmp("bresp", (a == 0) ? resp_okay : resp_slverr, s_axi_bresp);
    if (a == 0 && s[0]) prio_m[7:0] = dat[7:0] & 8'h77;
    if (a == 0 && s[1]) prio_m[15:8] = dat[15:8] & 8'h77;
  endtask

  task automatic rdv(logic [31:0] a);
    int n;
    n = 0;
    repeat (3) @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    s_axi_rready <= 1'b0;
    cmp("rdata", (a == 0) ? {16'h0, prio_m} : (a == 4) ? exp_stat() : 32'h0, s_axi_rdata);
    cmp("rresp", (a < 8) ? resp_okay : resp_slverr, s_axi_rresp);
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, src_req} = 104'h0;
    prio_m = prio_reset_val;
    void'($urandom(120));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdv(32'h0);
    rdv(32'h4);
    wr(32'h0, 32'hffffffff, 4'hf);
    rdv(32'h0);
    for (int k = 0; k < 40; k++) begin
      d = (k < 8) ? 32'h1111 * k : $urandom;
      src_req <= 4'($urandom);
      wr(32'h0, d, (k < 8) ? 4'h3 : 4'($urandom));
      rdv(32'h0);
      rdv(32'h4);
      cmp("src_enabled", {28'h0, exp_en()}, {28'h0, src_enabled});
      cmp("enabled_no_can", {28'h0, exp_en() & 4'h3}, {28'h0, en_nc});
    end
    wr(32'h4, 32'h0, 4'hf);
    wr(32'h8, 32'h0, 4'hf);
    rdv(32'h0);
    rdv(32'hc);
    give_verdict();
  end
endmodule // can_spi_irq_priority_reg_tb
